// file: hdl/dpwm_defines.svh
// Register indices, field positions and reset values of the dual PWM timer
`ifndef DPWM_DEFINES_SVH
`define DPWM_DEFINES_SVH

// Register indices; byte address is four times the index
`define DPWM_IDX_PRESCALER   8'h84
`define DPWM_IDX_PINFN_DIV   8'h85
`define DPWM_IDX_TIMER_CTRL  8'h86
`define DPWM_IDX_DEAD_ZONE   8'h87
`define DPWM_IDX_T0_COMPARE  8'h88
`define DPWM_IDX_T0_RELOAD   8'h8a
`define DPWM_IDX_T1_COMPARE  8'h8c
`define DPWM_IDX_T1_RELOAD   8'h8e
`define DPWM_IDX_IRQ_STATUS  8'h90
`define DPWM_IDX_IRQ_MASK    8'h91
`define DPWM_IDX_T0_COUNT    8'h92
`define DPWM_IDX_T1_COUNT    8'h94

// Timer control fields
`define DPWM_CTRL_RUN0       0
`define DPWM_CTRL_AUTO0      1
`define DPWM_CTRL_INV0       2
`define DPWM_CTRL_COMP       3
`define DPWM_CTRL_RUN1       4
`define DPWM_CTRL_AUTO1      5
`define DPWM_CTRL_INV1       6

// Pin function and divisor fields
`define DPWM_PF_OUT0_LSB     0
`define DPWM_PF_OUT1_LSB     2
`define DPWM_DIV0_LSB        4
`define DPWM_DIV1_LSB        6

// Pin function encodings
`define DPWM_PF_TIMER        2'h2
`define DPWM_PF_CLOCK        2'h3

// Interrupt status bits
`define DPWM_IRQ_T0_ZERO     0
`define DPWM_IRQ_T1_ZERO     1

// Reset values
`define DPWM_RST_BYTE        8'h00
`define DPWM_RST_WORD        16'h0000
`define DPWM_RST_IRQ         2'h0

`endif

// file: hdl/dpwm_pkg.sv
// Types shared by the dual PWM timer modules
package dpwm_pkg;
  typedef logic [15:0] dpwm_count_t;
  typedef logic [7:0]  dpwm_byte_t;
  typedef logic [1:0]  dpwm_sel_t;
endpackage

// file: hdl/dpwm_timer.sv
// One 16-bit down-counting PWM timer with clock divisor
`timescale 1ns/100ps
`include "dpwm_defines.svh"
module dpwm_timer
  import dpwm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Control
  input  wire logic        base_tick_in,
  input  wire dpwm_sel_t   div_sel_in,
  input  wire logic        run_in,
  input  wire logic        auto_in,
  input  wire logic        inv_in,
  input  wire dpwm_count_t reload_in,
  input  wire dpwm_count_t compare_in,
  // Status
  output dpwm_count_t      count_out,
  output logic             level_out,
  output logic             tick_out,
  output logic             zero_out
);
  logic [2:0]  div_cnt_r;
  logic [2:0]  div_mask;
  logic        tick;
  logic        run_d_r;
  dpwm_count_t cnt_r;
  logic        active_r;
  logic        zero_r;

  always_comb
  begin
    case (div_sel_in)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  assign tick = base_tick_in && ((div_cnt_r & div_mask) == div_mask);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      div_cnt_r <= 3'h0;
    else if (base_tick_in)
      div_cnt_r <= div_cnt_r + 3'h1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      run_d_r <= 1'b0;
    else
      run_d_r <= run_in;
  end

  // Reload and compare are read live; a new reload value governs the next period, a new compare value already the current one
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r    <= `DPWM_RST_WORD;
      active_r <= 1'b0;
      zero_r   <= 1'b0;
    end
    else
    begin
      zero_r <= 1'b0;
      if (run_in && !run_d_r)
      begin
        cnt_r    <= reload_in;
        active_r <= 1'b0;
      end
      else if (run_in && tick)
      begin
        if (cnt_r == 16'h0000)
        begin
          zero_r   <= 1'b1;
          active_r <= 1'b0;
          if (auto_in)
            cnt_r <= reload_in;
        end
        else
        begin
          cnt_r <= cnt_r - 16'h0001;
          if ((cnt_r - 16'h0001) == compare_in)
            active_r <= 1'b1;
        end
      end
    end
  end

  // Stopped timer gives a fixed level from the count against compare
  assign level_out = inv_in ^ (run_d_r ? active_r : (cnt_r < compare_in));
  assign count_out = cnt_r;
  assign tick_out  = tick;
  assign zero_out  = zero_r;

  a_load_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (run_in && !run_d_r) |=> (cnt_r == $past(reload_in)))
    else $error("timer did not load reload value on start");

  a_count_down: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (run_in && run_d_r && tick && cnt_r != 16'h0000) |=> (cnt_r == $past(cnt_r) - 16'h0001))
    else $error("timer did not decrement on tick");

  a_zero_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (run_in && run_d_r && tick && auto_in && cnt_r == 16'h0000)
      |=> (zero_out && !active_r && cnt_r == $past(reload_in)))
    else $error("zero count did not reload and raise event");

  a_fixed_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!run_in && !run_d_r && !inv_in) |-> (level_out == (cnt_r < compare_in)))
    else $error("fixed output level wrong");
endmodule

// file: hdl/dpwm_deadzone.sv
// Complementary output pair with dead zone
`timescale 1ns/100ps
`include "dpwm_defines.svh"
module dpwm_deadzone
  import dpwm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Control
  input  wire logic       tick_in,
  input  wire dpwm_byte_t length_in,
  input  wire logic       level_in,
  // Outputs
  output logic            pos_out,
  output logic            neg_out
);
  logic       held_r;
  dpwm_byte_t dz_cnt_r;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      held_r   <= 1'b0;
      dz_cnt_r <= `DPWM_RST_BYTE;
    end
    else if (level_in != held_r)
    begin
      held_r   <= level_in;
      dz_cnt_r <= length_in;
    end
    else if (tick_in && dz_cnt_r != 8'h00)
      dz_cnt_r <= dz_cnt_r - 8'h01;
  end

  // Both sides idle until the gap has run out
  assign pos_out = (dz_cnt_r == 8'h00) && held_r;
  assign neg_out = (dz_cnt_r == 8'h00) && !held_r;

  a_dead_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (level_in != held_r && length_in != 8'h00) |=> (!pos_out && !neg_out))
    else $error("outputs active during dead zone");
endmodule

// file: hdl/dpwm_top.sv
// Dual PWM timer with APB register file, pin multiplexing and interrupt
`timescale 1ns/100ps
`include "dpwm_defines.svh"
module dpwm_top
  import dpwm_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Multiplexed sources
  input  wire logic        port_c_bit7_pin_in,
  input  wire logic        sys_error_in,
  input  wire logic        osc_clk_in,
  // Pins and interrupt
  output logic             pwm_output_zero_out,
  output logic             pwm_output_one_out,
  output logic             irq_out
);
  // Registers
  dpwm_byte_t  prescaler_value_r;
  dpwm_byte_t  pin_function_and_divisor_r;
  dpwm_byte_t  timer_control_r;
  dpwm_byte_t  dead_zone_length_r;
  dpwm_count_t timer0_compare_r;
  dpwm_count_t timer0_reload_r;
  dpwm_count_t timer1_compare_r;
  dpwm_count_t timer1_reload_r;
  logic [1:0]  irq_status_r;
  logic [1:0]  irq_mask_r;

  // Bus
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        access;
  logic        wr_en;
  logic [7:0]  idx;
  logic        hit;
  logic [31:0] rd_data;
  logic [1:0]  irq_clear;

  // Tick and timers
  dpwm_byte_t  pre_cnt_r;
  logic        base_tick;
  dpwm_count_t t0_count;
  dpwm_count_t t1_count;
  logic        t0_level;
  logic        t1_level;
  logic        t0_tick;
  logic        t0_zero;
  logic        t1_zero;
  logic        dz_pos;
  logic        dz_neg;
  logic        comp_mode;

  // Pin logic
  logic        osc_meta_r;
  logic        osc_sync_r;
  logic        core_div_r;
  logic        pwm_output_zero_r;
  logic        pwm_output_one_r;
  logic        irq_r;
  logic        out0_nxt;
  logic        out1_nxt;
  dpwm_sel_t   fn0;
  dpwm_sel_t   fn1;

  assign idx       = paddr_in[9:2];
  assign access    = psel_in && penable_in;
  assign wr_en     = access && pready_r && pwrite_in && hit;
  assign comp_mode = timer_control_r[`DPWM_CTRL_COMP];
  assign fn0       = pin_function_and_divisor_r[`DPWM_PF_OUT0_LSB +: 2];
  assign fn1       = pin_function_and_divisor_r[`DPWM_PF_OUT1_LSB +: 2];
  assign irq_clear = (wr_en && pstrb_in[0] && idx == `DPWM_IDX_IRQ_STATUS) ? pwdata_in[1:0] : 2'h0;

  always_comb
  begin
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr_in[11:10] != 2'h0)
      hit = 1'b0;
    else
    begin
      case (idx)
        `DPWM_IDX_PRESCALER:  rd_data = {24'h00_0000, prescaler_value_r};
        `DPWM_IDX_PINFN_DIV:  rd_data = {24'h00_0000, pin_function_and_divisor_r};
        `DPWM_IDX_TIMER_CTRL: rd_data = {24'h00_0000, timer_control_r};
        `DPWM_IDX_DEAD_ZONE:  rd_data = {24'h00_0000, dead_zone_length_r};
        `DPWM_IDX_T0_COMPARE: rd_data = {16'h0000, timer0_compare_r};
        `DPWM_IDX_T0_RELOAD:  rd_data = {16'h0000, timer0_reload_r};
        `DPWM_IDX_T1_COMPARE: rd_data = {16'h0000, timer1_compare_r};
        `DPWM_IDX_T1_RELOAD:  rd_data = {16'h0000, timer1_reload_r};
        `DPWM_IDX_IRQ_STATUS: rd_data = {30'h0000_0000, irq_status_r};
        `DPWM_IDX_IRQ_MASK:   rd_data = {30'h0000_0000, irq_mask_r};
        `DPWM_IDX_T0_COUNT:   rd_data = {16'h0000, t0_count};
        `DPWM_IDX_T1_COUNT:   rd_data = {16'h0000, t1_count};
        default:              hit = 1'b0;
      endcase
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else if (access && !pready_r)
    begin
      pready_r  <= 1'b1;
      pslverr_r <= !hit;
      prdata_r  <= pwrite_in ? 32'h0000_0000 : rd_data;
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // Byte registers use lane 0, halfword registers lanes 0 and 1
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      prescaler_value_r          <= `DPWM_RST_BYTE;
      pin_function_and_divisor_r <= `DPWM_RST_BYTE;
      timer_control_r            <= `DPWM_RST_BYTE;
      dead_zone_length_r         <= `DPWM_RST_BYTE;
    end
    else if (wr_en && pstrb_in[0])
    begin
      case (idx)
        `DPWM_IDX_PRESCALER:  prescaler_value_r          <= pwdata_in[7:0];
        `DPWM_IDX_PINFN_DIV:  pin_function_and_divisor_r <= pwdata_in[7:0];
        `DPWM_IDX_TIMER_CTRL: timer_control_r            <= pwdata_in[7:0];
        `DPWM_IDX_DEAD_ZONE:  dead_zone_length_r         <= pwdata_in[7:0];
        default:              ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      timer0_compare_r <= `DPWM_RST_WORD;
      timer0_reload_r  <= `DPWM_RST_WORD;
      timer1_compare_r <= `DPWM_RST_WORD;
      timer1_reload_r  <= `DPWM_RST_WORD;
    end
    else if (wr_en)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (pstrb_in[b])
        begin
          case (idx)
            `DPWM_IDX_T0_COMPARE: timer0_compare_r[b*8 +: 8] <= pwdata_in[b*8 +: 8];
            `DPWM_IDX_T0_RELOAD:  timer0_reload_r[b*8 +: 8]  <= pwdata_in[b*8 +: 8];
            `DPWM_IDX_T1_COMPARE: timer1_compare_r[b*8 +: 8] <= pwdata_in[b*8 +: 8];
            `DPWM_IDX_T1_RELOAD:  timer1_reload_r[b*8 +: 8]  <= pwdata_in[b*8 +: 8];
            default:              ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      irq_mask_r <= `DPWM_RST_IRQ;
    else if (wr_en && pstrb_in[0] && idx == `DPWM_IDX_IRQ_MASK)
      irq_mask_r <= pwdata_in[1:0];
  end

  // A new zero event wins over a simultaneous write-one clear
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      irq_status_r <= `DPWM_RST_IRQ;
    else
      irq_status_r <= (irq_status_r & ~irq_clear) | {t1_zero, t0_zero};
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_status_r & irq_mask_r);
  end

  // Shared prescaler
  assign base_tick = (pre_cnt_r == prescaler_value_r);

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      pre_cnt_r <= `DPWM_RST_BYTE;
    else if (base_tick || pre_cnt_r > prescaler_value_r)
      pre_cnt_r <= 8'h00;
    else
      pre_cnt_r <= pre_cnt_r + 8'h01;
  end

  dpwm_timer u_timer0 (
    .clk_in       (core_clk_in),
    .rst_n_in     (rst_n_in),
    .base_tick_in (base_tick),
    .div_sel_in   (pin_function_and_divisor_r[`DPWM_DIV0_LSB +: 2]),
    .run_in       (timer_control_r[`DPWM_CTRL_RUN0]),
    .auto_in      (timer_control_r[`DPWM_CTRL_AUTO0]),
    .inv_in       (timer_control_r[`DPWM_CTRL_INV0]),
    .reload_in    (timer0_reload_r),
    .compare_in   (timer0_compare_r),
    .count_out    (t0_count),
    .level_out    (t0_level),
    .tick_out     (t0_tick),
    .zero_out     (t0_zero)
  );

  dpwm_timer u_timer1 (
    .clk_in       (core_clk_in),
    .rst_n_in     (rst_n_in),
    .base_tick_in (base_tick),
    .div_sel_in   (pin_function_and_divisor_r[`DPWM_DIV1_LSB +: 2]),
    .run_in       (timer_control_r[`DPWM_CTRL_RUN1]),
    .auto_in      (timer_control_r[`DPWM_CTRL_AUTO1]),
    .inv_in       (timer_control_r[`DPWM_CTRL_INV1]),
    .reload_in    (timer1_reload_r),
    .compare_in   (timer1_compare_r),
    .count_out    (t1_count),
    .level_out    (t1_level),
    .tick_out     (),
    .zero_out     (t1_zero)
  );

  dpwm_deadzone u_deadzone (
    .clk_in    (core_clk_in),
    .rst_n_in  (rst_n_in),
    .tick_in   (t0_tick),
    .length_in (dead_zone_length_r),
    .level_in  (t0_level),
    .pos_out   (dz_pos),
    .neg_out   (dz_neg)
  );

  // Oscillator clock is only a sampled copy, aliased above 100 MHz
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end
    else
    begin
      osc_meta_r <= osc_clk_in;
      osc_sync_r <= osc_meta_r;
    end
  end

  always_comb
  begin
    if (!fn0[1])
      out0_nxt = port_c_bit7_pin_in;
    else if (fn0 == `DPWM_PF_TIMER)
      out0_nxt = comp_mode ? dz_pos : t0_level;
    else
      out0_nxt = core_div_r;
    if (!fn1[1])
      out1_nxt = sys_error_in;
    else if (fn1 == `DPWM_PF_TIMER)
      out1_nxt = comp_mode ? dz_neg : t1_level;
    else
      out1_nxt = osc_sync_r;
  end

  // Core clock seen on the pin runs at half rate from a flop
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      core_div_r <= 1'b0;
      pwm_output_zero_r     <= 1'b0;
      pwm_output_one_r     <= 1'b0;
    end
    else
    begin
      core_div_r <= !core_div_r;
      pwm_output_zero_r     <= out0_nxt;
      pwm_output_one_r     <= out1_nxt;
    end
  end

  assign prdata_out          = prdata_r;
  assign pready_out          = pready_r;
  assign pslverr_out         = pslverr_r;
  assign pwm_output_zero_out = pwm_output_zero_r;
  assign pwm_output_one_out  = pwm_output_one_r;
  assign irq_out             = irq_r;

  sequence s_ctrl_write;
    psel_in && penable_in && pready_r && pwrite_in && pstrb_in[0] && idx == `DPWM_IDX_TIMER_CTRL
      && paddr_in[11:10] == 2'h0;
  endsequence
  sequence s_ctrl_updated;
    ##1 timer_control_r == $past(pwdata_in[7:0]);
  endsequence
  a_ctrl_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_ctrl_write |-> s_ctrl_updated)
    else $error("timer control write not stored");
  a_apb_ready: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (psel_in && !penable_in) ##1 (psel_in && penable_in) |=> pready_out)
    else $error("apb answer not after one wait state");
  a_irq_event: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (t0_zero && irq_mask_r[0]) |=> irq_status_r[0] ##1 irq_out)
    else $error("timer zero event did not raise interrupt");
  // Spacing only holds while the prescaler is left alone
  a_prescale_gap: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (base_tick && prescaler_value_r == 8'h01) ##1 $stable(prescaler_value_r) |-> !base_tick)
    else $error("prescaler tick spacing wrong");
  a_mux_timer0: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (fn0 == `DPWM_PF_TIMER && !comp_mode) |=> (pwm_output_zero_out == $past(t0_level)))
    else $error("output zero not timer zero");
  a_mux_gpio: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!fn0[1]) |=> (pwm_output_zero_out == $past(port_c_bit7_pin_in)))
    else $error("output zero not general pin");
  a_mux_error: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!fn1[1]) |=> (pwm_output_one_out == $past(sys_error_in)))
    else $error("output one not error flag");
  a_comp_apart: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (comp_mode && fn0 == `DPWM_PF_TIMER && fn1 == `DPWM_PF_TIMER)
      |=> !(pwm_output_zero_out && pwm_output_one_out))
    else $error("complementary outputs both active");
endmodule

// file: bench/dpwm_load_model.sv
// Load model on the PWM pins: measures high time, period and overlap
`timescale 1ns/100ps
module dpwm_load_model
(
  // Clock
  input  wire logic clk_in,
  // Pins
  input  wire logic pwm_output_zero_in,
  input  wire logic pwm_output_one_in,
  // Measurements in clock cycles
  output int        high0_out,
  output int        per0_out,
  output int        high1_out,
  output int        per1_out,
  output int        overlap_out
);
  logic [1:0] pins;
  logic [1:0] last;
  int         since [2];
  int         run [2];
  int         high [2];
  int         per [2];

  assign pins = {pwm_output_one_in, pwm_output_zero_in};
  assign high0_out = high[0];
  assign per0_out = per[0];
  assign high1_out = high[1];
  assign per1_out = per[1];

  initial
  begin
    last = 2'h0;
    since = '{0, 0};
    run = '{0, 0};
    high = '{0, 0};
    per = '{0, 0};
    overlap_out = 0;
  end

  // Period updates at each rising pin edge and high time at each falling one, so a pulse cut by a reconfiguration shows up once
  always @(posedge clk_in)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (pins[i] && !last[i])
      begin
        per[i] <= since[i];
        since[i] <= 1;
      end
      else
        since[i] <= since[i] + 1;
      run[i] <= pins[i] ? run[i] + 1 : 0;
      if (!pins[i] && last[i])
        high[i] <= run[i];
    end
    last <= pins;
    if (pins === 2'h3)
      overlap_out <= overlap_out + 1;
  end
endmodule

// file: bench/dpwm_top_tb_top.sv
// Testbench for the dual PWM timer: APB tasks and directed scenarios
`timescale 1ns/100ps
`include "dpwm_defines.svh"
module dpwm_top_tb_top;
  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_c;
  logic        sys_err;
  logic        osc_clk;
  logic        pwm_output_zero;
  logic        pwm_output_one;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic        b;
  int          n_mismatch;
  int          n_tests;
  int          high0;
  int          per0;
  int          high1;
  int          per1;
  int          overlap;
  int          ov0;
  logic [7:0]  idx_tab [10] = '{`DPWM_IDX_PRESCALER, `DPWM_IDX_PINFN_DIV, `DPWM_IDX_TIMER_CTRL,
    `DPWM_IDX_DEAD_ZONE, `DPWM_IDX_T0_COMPARE, `DPWM_IDX_T0_RELOAD, `DPWM_IDX_T1_COMPARE,
    `DPWM_IDX_T1_RELOAD, `DPWM_IDX_IRQ_STATUS, `DPWM_IDX_IRQ_MASK};

  dpwm_top dpwm_top_i (.core_clk_in(core_clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .port_c_bit7_pin_in(pin_c), .sys_error_in(sys_err),
    .osc_clk_in(osc_clk), .pwm_output_zero_out(pwm_output_zero), .pwm_output_one_out(pwm_output_one), .irq_out(irq));

  dpwm_load_model dpwm_load_model_i (.clk_in(core_clk), .pwm_output_zero_in(pwm_output_zero), .pwm_output_one_in(pwm_output_one), .high0_out(high0),
    .per0_out(per0), .high1_out(high1), .per1_out(per1), .overlap_out(overlap));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Waits on pready without a bound; the watchdog covers a slave that never answers
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] strb);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    pstrb <= strb;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, 4'hf);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, 4'hf);
    chk(rd, exp);
  endtask

  initial
  begin
    #100us;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {pin_c, sys_err, osc_clk, rst_n} = 4'h0;
    n_mismatch = 0;
    n_tests = 0;
    cyc(4);
    rst_n <= 1'b1;
    foreach (idx_tab[i]) rchk(idx_tab[i], 32'h0);
    wr(`DPWM_IDX_PRESCALER, 32'h1234_56a5);
    rchk(`DPWM_IDX_PRESCALER, 32'ha5);
    apb(1'b1, `DPWM_IDX_PRESCALER, 32'h5a, 4'he);
    rchk(`DPWM_IDX_PRESCALER, 32'ha5);
    wr(`DPWM_IDX_T0_COMPARE, 32'hbeef_1234);
    rchk(`DPWM_IDX_T0_COMPARE, 32'h1234);
    wr(`DPWM_IDX_T0_COUNT, 32'h1234);
    rchk(`DPWM_IDX_T0_COUNT, 32'h0);
    apb(1'b0, 8'h7f, 32'h0, 4'hf);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // Base tick every 2 clocks; timer tick 2 << d clocks; 6 ticks a period, 2 active
    wr(`DPWM_IDX_PRESCALER, 32'h1);
    wr(`DPWM_IDX_T0_RELOAD, 32'h5);
    wr(`DPWM_IDX_T0_COMPARE, 32'h1);
    wr(`DPWM_IDX_TIMER_CTRL, 32'h3);
    for (int d = 0; d < 4; d++)
    begin
      wr(`DPWM_IDX_PINFN_DIV, 32'h02 | (d << 4));
      cyc(48 << d);
      chk(per0, 12 << d);
      chk(high0, 4 << d);
    end
    wr(`DPWM_IDX_PINFN_DIV, 32'h22);
    cyc(150);
    chk(per0, 48);
    chk(high0, 16);
    wr(`DPWM_IDX_TIMER_CTRL, 32'h7);
    cyc(150);
    chk(high0, 32);
    wr(`DPWM_IDX_TIMER_CTRL, 32'h3);
    wr(`DPWM_IDX_T0_COMPARE, 32'h3);
    cyc(150);
    chk(high0, 32);
    rchk(`DPWM_IDX_IRQ_STATUS, 32'h1);
    chk(irq, 1'b0);
    wr(`DPWM_IDX_IRQ_MASK, 32'h1);
    cyc(3);
    chk(irq, 1'b1);
    wr(`DPWM_IDX_TIMER_CTRL, 32'h0);
    wr(`DPWM_IDX_IRQ_STATUS, 32'h1);
    cyc(3);
    chk(irq, 1'b0);
    rchk(`DPWM_IDX_IRQ_STATUS, 32'h0);
    wr(`DPWM_IDX_T0_COMPARE, 32'hffff);
    cyc(3);
    chk(pwm_output_zero, 1'b1);
    wr(`DPWM_IDX_T0_COMPARE, 32'h0);
    cyc(3);
    chk(pwm_output_zero, 1'b0);
    wr(`DPWM_IDX_TIMER_CTRL, 32'h4);
    cyc(3);
    chk(pwm_output_zero, 1'b1);
    wr(`DPWM_IDX_TIMER_CTRL, 32'h0);
    wr(`DPWM_IDX_PINFN_DIV, 32'h0);
    for (int v = 1; v >= 0; v--)
    begin
      pin_c <= v[0];
      sys_err <= v[0];
      cyc(3);
      chk(pwm_output_zero, v[0]);
      chk(pwm_output_one, v[0]);
    end
    wr(`DPWM_IDX_PINFN_DIV, 32'h0c);
    for (int v = 1; v >= 0; v--)
    begin
      osc_clk <= v[0];
      cyc(5);
      chk(pwm_output_one, v[0]);
    end
    wr(`DPWM_IDX_PINFN_DIV, 32'h03);
    cyc(3);
    b = pwm_output_zero;
    cyc(1);
    chk(pwm_output_zero, !b);
    // Timer one on its own controls, one tick per clock
    wr(`DPWM_IDX_PRESCALER, 32'h0);
    wr(`DPWM_IDX_PINFN_DIV, 32'h0a);
    wr(`DPWM_IDX_T1_RELOAD, 32'h5);
    wr(`DPWM_IDX_T1_COMPARE, 32'h1);
    wr(`DPWM_IDX_TIMER_CTRL, 32'h30);
    cyc(40);
    chk(per1, 6);
    chk(high1, 2);
    rchk(`DPWM_IDX_IRQ_STATUS, 32'h2);
    // Complementary: 5 active and 5 idle ticks, each side loses 2 to the dead zone
    wr(`DPWM_IDX_DEAD_ZONE, 32'h2);
    wr(`DPWM_IDX_T0_RELOAD, 32'h9);
    wr(`DPWM_IDX_T0_COMPARE, 32'h4);
    wr(`DPWM_IDX_TIMER_CTRL, 32'h0b);
    cyc(40);
    ov0 = overlap;
    cyc(60);
    chk(overlap, ov0);
    chk(per1, 10);
    chk(high0, 3);
    chk(high1, 3);
    finish_test();
  end
endmodule
